// File: rtl/ddcsel_top.sv
// Purpose : Source, rate and oscillator channel configuration of the
//           first downconverter, reached over classic Wishbone.
// Assumes : One 125 MHz clock; pins synchronous; 8-bit registers in
//           the low byte of each 32-bit word, byte lane 0 only.
// Notes   : Every output is registered; settings take two edges to show.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module ddcsel_top
  import ddcsel_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [11:0]      wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic      [31:0]      wb_dat_out,
  output logic                  wb_ack_out,
  input  wire logic             pin_a_first_in,
  input  wire logic             pin_a_second_in,
  input  wire logic             pin_b_first_in,
  input  wire logic             pin_b_second_in,
  output logic      [STG_W-1:0] stage_en_out,
  output logic      [DEC_W-1:0] decim_factor_out,
  output logic                  rate_ok_out,
  output logic                  real_only_out,
  output logic                  i_src_b_out,
  output logic                  q_src_b_out,
  output logic      [3:0]       nco_chan_out
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [9:0]       idx;
  logic             req;
  logic             wr_go;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [3:0]       rate_ctrl_q;
  logic [7:0]       src_rate_q;
  logic [7:0]       osc_q;
  logic [7:0]       rd_byte;
  ddcsel_stage_t    stage_c;
  logic [DEC_W-1:0] decim_c;
  logic             ok_c;
  logic [3:0]       chan_c;
  logic [3:0]       cnt_c;
  logic             edge_c;
  logic [3:0]       pins;

  // Word index; the two low address bits are don't-care
  assign idx   = wb_adr_in[11:2];
  assign req   = wb_cyc_in && wb_stb_in && !ack_q;
  // Writes land on the edge that raises ack, lane 0 only
  assign wr_go = req && wb_we_in && wb_sel_in[0];
  assign pins  = {pin_b_second_in, pin_b_first_in, pin_a_second_in, pin_a_first_in};

  // ----------------------------------------------------------------
  // Acknowledge: one wait state, dropped the cycle after
  // ----------------------------------------------------------------
  // Gating by ack_q stops a held request being taken twice
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign wb_ack_out = ack_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Main rate select and real enable, kept here since the rate logic needs them
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rate_ctrl_q <= RST_RATE_CTRL;
    end else if (wr_go && idx == IDX_RATE_CTRL) begin
      rate_ctrl_q <= wb_dat_in[3:0];
    end
  end

  // Source and extended rate; reserved bits stay zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      src_rate_q <= RST_SRC_RATE;
    end else if (wr_go && idx == IDX_SRC_RATE) begin
      src_rate_q <= wb_dat_in[7:0] & SRC_RATE_WMASK;
    end
  end

  // Oscillator channel control, fully read-write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      osc_q <= RST_OSC_CHAN;
    end else if (wr_go && idx == IDX_OSC_CHAN) begin
      osc_q <= wb_dat_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped words read as zero and still acknowledge
  always_comb begin
    unique case (idx)
      IDX_RATE_CTRL: rd_byte = {4'h0, rate_ctrl_q};
      IDX_SRC_RATE:  rd_byte = src_rate_q;
      IDX_OSC_CHAN:  rd_byte = osc_q;
      IDX_STATUS:    rd_byte = {2'h0, real_only_out, rate_ok_out, nco_chan_out};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Data is captured with ack so it is stable while ack is high
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdat_q <= 32'h0000_0000;
    end else if (req) begin
      rdat_q <= {24'h00_0000, rd_byte};
    end
  end
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------
  // Rate and channel logic
  // ----------------------------------------------------------------
  ddcsel_rate_decode u_rate (
    .main_sel_in (rate_ctrl_q[MAIN_SEL_MSB:0]),
    .ext_code_in (src_rate_q[EXT_MSB:EXT_LSB]),
    .real_in     (rate_ctrl_q[REAL_BIT]),
    .stage_out   (stage_c),
    .decim_out   (decim_c),
    .ok_out      (ok_c)
  );

  ddcsel_chan_sel u_chan (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .mode_in       (osc_q[MODE_MSB:MODE_LSB]),
    .chan_field_in (osc_q[CHAN_MSB:0]),
    .pins_in       (pins),
    .chan_out      (chan_c),
    .cnt_out       (cnt_c),
    .edge_mode_out (edge_c)
  );

  // Rate outputs registered; the decode is a deep mux
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      stage_en_out     <= '0;
      decim_factor_out <= '0;
      rate_ok_out      <= 1'b0;
      real_only_out    <= 1'b0;
    end else begin
      stage_en_out     <= stage_c;
      decim_factor_out <= decim_c;
      rate_ok_out      <= ok_c;
      real_only_out    <= rate_ctrl_q[REAL_BIT];
    end
  end

  // Path sources: clear is channel A, set is channel B
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      i_src_b_out <= 1'b0;
      q_src_b_out <= 1'b0;
    end else begin
      i_src_b_out <= src_rate_q[I_SRC_BIT];
      q_src_b_out <= src_rate_q[Q_SRC_BIT];
    end
  end

  // Active channel, one of sixteen
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      nco_chan_out <= 4'h0;
    end else begin
      nco_chan_out <= chan_c;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [2:0] main_s;
  logic [3:0] ext_s;
  logic [3:0] mode_s;
  logic       real_s;
  assign main_s = rate_ctrl_q[MAIN_SEL_MSB:0];
  assign ext_s  = src_rate_q[EXT_MSB:EXT_LSB];
  assign mode_s = osc_q[MODE_MSB:MODE_LSB];
  assign real_s = rate_ctrl_q[REAL_BIT];

  a_ext_gated: assert property (
    (main_s != MAIN_EXT) |=> ((stage_en_out & (STG_FB | STG_TB1)) == '0))
    else $error("extended stages used without extended select");

  a_ext48_rate: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D48)
      |=> decim_factor_out == ($past(real_s) ? 6'h18 : 6'h30) && stage_en_out[5])
    else $error("extended code zero rate wrong");

  a_fifth_rate: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D20)
      |=> stage_en_out == (STG_FB | STG_HB2 | STG_HB1)
          && decim_factor_out == ($past(real_s) ? 6'h0a : 6'h14))
    else $error("fifthband chain rate wrong");

  a_third_unsup: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D15)
      |=> (rate_ok_out != $past(real_s)) && decim_factor_out == ($past(real_s) ? 6'h00 : 6'h0f))
    else $error("thirdband real variant not refused");

  a_src_route: assert property (
    (wb_ack_out && wb_we_in && wb_sel_in[0] && idx == IDX_SRC_RATE)
      |=> i_src_b_out == $past(wb_dat_in[I_SRC_BIT])
          && q_src_b_out == $past(wb_dat_in[Q_SRC_BIT]))
    else $error("path source does not follow write");

  a_reg_chan: assert property (
    (mode_s == MODE_REG) |=> nco_chan_out == $past(osc_q[CHAN_MSB:0]))
    else $error("register channel not applied");

  a_pin_chan: assert property (
    (mode_s == MODE_ILV_X) ##1 (mode_s == MODE_ILV_X)
      |-> nco_chan_out == {$past(pin_b_second_in), $past(pin_a_second_in),
                           $past(pin_b_first_in), $past(pin_a_first_in)})
    else $error("interleaved pin channel wrong");

  a_pair_chan: assert property (
    (mode_s == MODE_BB) |=> nco_chan_out[3:2] == 2'h0)
    else $error("pin pair mode upper bits not zero");

  a_edge_step: assert property (
    (mode_s == 4'h9 && $stable(mode_s) && $rose(pin_a_second_in)
      && cnt_c < osc_q[CHAN_MSB:0]) |=> cnt_c == $past(cnt_c) + 4'h1)
    else $error("edge counter did not step");

  // Rise is taken from the whole pin vector so a mode change never fakes one
  a_edge_hold: assert property (
    (edge_c && (((pins & ~$past(pins)) >> mode_s[1:0]) & 4'h1) == 4'h0) |=> $stable(cnt_c))
    else $error("edge counter moved without an edge");

  a_edge_wrap: assert property (
    (edge_c && $past(edge_c) && (((pins & ~$past(pins)) >> mode_s[1:0]) & 4'h1) != 4'h0
      && cnt_c >= osc_q[CHAN_MSB:0]) |=> cnt_c == 4'h0 ##1 nco_chan_out == 4'h0)
    else $error("edge counter did not wrap");

  a_real_half: assert property (
    (real_s && main_s == 3'h0) |=> real_only_out && decim_factor_out == 6'h02)
    else $error("real output rate wrong");

  a_reserved_mode: assert property (
    (mode_s == 4'h7 || mode_s[3:2] == 2'h3) |=> nco_chan_out == $past(osc_q[CHAN_MSB:0]))
    else $error("reserved mode did not fall back");

  a_ack_pulse: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  // Remaining extended codes, each but EXT_D30 against its fixed chain
  a_ext10_rate: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D10)
      |=> stage_en_out == (STG_FB | STG_HB1)
          && decim_factor_out == ($past(real_s) ? 6'h05 : 6'h0a))
    else $error("fifthband after stage one wrong");

  a_ext40_rate: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D40)
      |=> stage_en_out == (STG_FB | STG_HB3 | STG_HB2 | STG_HB1)
          && decim_factor_out == ($past(real_s) ? 6'h14 : 6'h28))
    else $error("fifthband after stage three wrong");

  // Thirdband chains have no real variant, so real must refuse them
  a_third_alone: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D3)
      |=> stage_en_out == ($past(real_s) ? 7'h00 : STG_TB1)
          && decim_factor_out == ($past(real_s) ? 6'h00 : 6'h03))
    else $error("thirdband alone rate wrong");

  a_third_30: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D30)
      |=> rate_ok_out == !$past(real_s)
          && decim_factor_out == ($past(real_s) ? 6'h00 : 6'h1e))
    else $error("thirdband by thirty rate wrong");

  a_ext48_chain: assert property (
    (main_s == MAIN_EXT && ext_s == EXT_D48)
      |=> stage_en_out == (STG_TB2 | STG_HB4 | STG_HB3 | STG_HB2 | STG_HB1))
    else $error("extended code zero chain wrong");

  // Two-pin modes keep the upper channel bits at zero
  a_pair_aa: assert property (
    (mode_s == MODE_AA)
      |=> nco_chan_out == {2'h0, $past(pin_a_second_in), $past(pin_a_first_in)})
    else $error("a pin pair channel wrong");

  a_ilv_ordered: assert property (
    (mode_s == MODE_ILV_Y) |=> nco_chan_out == $past(pins))
    else $error("ordered pin channel wrong");

  // Counter must restart from zero on entry to an edge mode
  a_edge_idle: assert property (
    !edge_c |=> cnt_c == 4'h0)
    else $error("edge counter not held outside edge modes");

  // Writes commit on the request edge, so data is in place with ack
  a_wr_commit: assert property (
    (wb_ack_out && wb_we_in && wb_sel_in[0] && idx == IDX_OSC_CHAN)
      |-> osc_q == wb_dat_in[7:0])
    else $error("channel field write not stored");

  a_sel_refuse: assert property (
    (req && wb_we_in && !wb_sel_in[0]) |=> $stable(osc_q) && $stable(src_rate_q))
    else $error("write with lane zero off was stored");

  a_rd_upper: assert property (
    wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  c_ext48: cover property (main_s == MAIN_EXT && ext_s == EXT_D48 && real_s);
  c_edge_wrap: cover property (edge_c && cnt_c == osc_q[CHAN_MSB:0] ##1 cnt_c == 4'h0);
  c_interleave: cover property (mode_s == MODE_ILV_Y && nco_chan_out == 4'hf);
  c_chan_b: cover property (i_src_b_out && q_src_b_out);
  c_edge_last: cover property (mode_s == 4'hb && cnt_c == 4'h2);
endmodule : ddcsel_top

// File: rtl/ddcsel_pkg.sv
// Purpose : Shared constants for first downconverter source, rate and
//           oscillator channel selection.
// Assumes : Registers are 8 bits wide, one per 32-bit Wishbone word.
// Notes   : Byte address of a register is four times its index.
package ddcsel_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_RATE_CTRL = 10'h310;
  localparam logic [9:0] IDX_SRC_RATE  = 10'h311;
  localparam logic [9:0] IDX_OSC_CHAN  = 10'h314;
  localparam logic [9:0] IDX_STATUS    = 10'h3f0;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_RATE_CTRL  = 4'h0;
  localparam logic [7:0] RST_SRC_RATE   = 8'h00;
  localparam logic [7:0] RST_OSC_CHAN   = 8'h00;
  localparam logic [7:0] SRC_RATE_WMASK = 8'hf5; // Bits 3 and 1 reserved

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAIN_SEL_MSB = 2;
  localparam int REAL_BIT     = 3;
  localparam int EXT_MSB      = 7;
  localparam int EXT_LSB      = 4;
  localparam int Q_SRC_BIT    = 2;
  localparam int I_SRC_BIT    = 0;
  localparam int MODE_MSB     = 7;
  localparam int MODE_LSB     = 4;
  localparam int CHAN_MSB     = 3;
  localparam int ST_REAL_BIT  = 5;
  localparam int ST_OK_BIT    = 4;

  // ----------------------------------------------------------------
  // Rate codes, stage masks and channel source modes
  // ----------------------------------------------------------------
  localparam int STG_W = 7;
  localparam int DEC_W = 6;
  typedef logic [STG_W-1:0] ddcsel_stage_t;
  localparam ddcsel_stage_t STG_HB1 = 7'h01;
  localparam ddcsel_stage_t STG_HB2 = 7'h02;
  localparam ddcsel_stage_t STG_HB3 = 7'h04;
  localparam ddcsel_stage_t STG_HB4 = 7'h08;
  localparam ddcsel_stage_t STG_TB1 = 7'h10;
  localparam ddcsel_stage_t STG_TB2 = 7'h20;
  localparam ddcsel_stage_t STG_FB  = 7'h40;
  localparam logic [2:0] MAIN_EXT = 3'h7;
  localparam logic [3:0] EXT_D48 = 4'h0;
  localparam logic [3:0] EXT_D10 = 4'h2;
  localparam logic [3:0] EXT_D20 = 4'h3;
  localparam logic [3:0] EXT_D40 = 4'h4;
  localparam logic [3:0] EXT_D3  = 4'h7;
  localparam logic [3:0] EXT_D15 = 4'h8;
  localparam logic [3:0] EXT_D30 = 4'h9;
  localparam logic [3:0] MODE_REG    = 4'h0;
  localparam logic [3:0] MODE_BA_1ST = 4'h1;
  localparam logic [3:0] MODE_BA_2ND = 4'h2;
  localparam logic [3:0] MODE_AA     = 4'h3;
  localparam logic [3:0] MODE_BB     = 4'h4;
  localparam logic [3:0] MODE_ILV_X  = 4'h5;
  localparam logic [3:0] MODE_ILV_Y  = 4'h6;
  localparam logic [3:0] MODE_EDGE_0 = 4'h8; // Edge modes 8..11
endpackage : ddcsel_pkg

// File: rtl/ddcsel_rate_decode.sv
// Purpose : Decode rate codes into filter stage enables and decimation.
// Assumes : Purely combinational; the caller registers the results.
// Notes   : Unsupported combinations give zero stages and ok low.
`timescale 1ns/1ps
module ddcsel_rate_decode
  import ddcsel_pkg::*;
(
  input  wire logic [2:0]       main_sel_in,
  input  wire logic [3:0]       ext_code_in,
  input  wire logic             real_in,
  output ddcsel_stage_t         stage_out,
  output logic      [DEC_W-1:0] decim_out,
  output logic                  ok_out
);
  // ----------------------------------------------------------------
  // Stage table: complex factor, real output allowed or not
  // ----------------------------------------------------------------
  ddcsel_stage_t    stage;
  logic [DEC_W-1:0] full;
  logic             half_ok;

  always_comb begin
    stage   = '0;
    full    = '0;
    half_ok = 1'b0;
    unique case (main_sel_in)
      3'h0: begin stage = STG_HB1 | STG_HB2; full = 6'h04; half_ok = 1'b1; end
      3'h1: begin stage = STG_HB1 | STG_HB2 | STG_HB3; full = 6'h08; half_ok = 1'b1; end
      3'h2: begin stage = STG_HB1 | STG_HB2 | STG_HB3 | STG_HB4; full = 6'h10; half_ok = 1'b1; end
      3'h3: begin stage = STG_HB1; full = 6'h02; half_ok = 1'b1; end
      3'h4: begin stage = STG_HB1 | STG_TB2; full = 6'h06; half_ok = 1'b1; end
      3'h5: begin stage = STG_HB1 | STG_HB2 | STG_TB2; full = 6'h0c; half_ok = 1'b1; end
      3'h6: begin
        stage   = STG_HB1 | STG_HB2 | STG_HB3 | STG_TB2;
        full    = 6'h18;
        half_ok = 1'b1;
      end
      MAIN_EXT: begin
        // Extended code only matters here
        unique case (ext_code_in)
          EXT_D48: begin // By 48, or 24 real
            stage   = STG_TB2 | STG_HB4 | STG_HB3 | STG_HB2 | STG_HB1;
            full    = 6'h30;
            half_ok = 1'b1;
          end
          EXT_D10: begin stage = STG_FB | STG_HB1; full = 6'h0a; half_ok = 1'b1; end
          EXT_D20: begin stage = STG_FB | STG_HB2 | STG_HB1; full = 6'h14; half_ok = 1'b1; end
          EXT_D40: begin
            stage   = STG_FB | STG_HB3 | STG_HB2 | STG_HB1;
            full    = 6'h28;
            half_ok = 1'b1;
          end
          EXT_D3:  begin stage = STG_TB1; full = 6'h03; end // No real variant
          EXT_D15: begin stage = STG_FB | STG_TB1; full = 6'h0f; end
          EXT_D30: begin stage = STG_HB2 | STG_FB | STG_TB1; full = 6'h1e; end
          default: begin stage = '0; full = '0; half_ok = 1'b0; end
        endcase
      end
    endcase
  end

  // Real output halves the rate where allowed
  always_comb begin
    ok_out    = (full != '0) && (!real_in || half_ok);
    stage_out = ok_out ? stage : '0;
    decim_out = !ok_out ? '0 : (real_in ? (full >> 1) : full);
  end
endmodule : ddcsel_rate_decode

// File: rtl/ddcsel_chan_sel.sv
// Purpose : Pick the active oscillator channel from register, pins or counter.
// Assumes : Pins are synchronous to sys_clk_in.
// Notes   : Counter is held at zero outside the edge modes.
`timescale 1ns/1ps
module ddcsel_chan_sel
  import ddcsel_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] mode_in,
  input  wire logic [3:0] chan_field_in,
  input  wire logic [3:0] pins_in,     // {b_second, b_first, a_second, a_first}
  output logic      [3:0] chan_out,
  output logic      [3:0] cnt_out,
  output logic            edge_mode_out
);
  // ----------------------------------------------------------------
  // Rising edge detection, one flop per pin
  // ----------------------------------------------------------------
  logic [3:0] prev_q;
  logic [3:0] rise;
  logic [3:0] cnt_q;
  logic       step;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          prev_q[g] <= 1'b0;
        end else begin
          prev_q[g] <= pins_in[g];
        end
      end
      assign rise[g] = pins_in[g] & ~prev_q[g];
    end
  endgenerate

  // Modes 8..11 pick pins a_first, a_second, b_first, b_second
  assign edge_mode_out = (mode_in[3:2] == MODE_EDGE_0[3:2]);
  assign step          = edge_mode_out && rise[mode_in[1:0]];

  // Counter wraps to zero after reaching the channel field
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      cnt_q <= 4'h0;
    end else if (!edge_mode_out) begin
      cnt_q <= 4'h0;
    end else if (step) begin
      cnt_q <= (cnt_q >= chan_field_in) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  assign cnt_out = cnt_q;

  // Channel source mux; reserved modes use the register field
  always_comb begin
    unique case (mode_in)
      MODE_REG:    chan_out = chan_field_in;
      MODE_BA_1ST: chan_out = {2'h0, pins_in[2], pins_in[0]};
      MODE_BA_2ND: chan_out = {2'h0, pins_in[3], pins_in[1]};
      MODE_AA:     chan_out = {2'h0, pins_in[1], pins_in[0]};
      MODE_BB:     chan_out = {2'h0, pins_in[3], pins_in[2]};
      MODE_ILV_X:  chan_out = {pins_in[3], pins_in[1], pins_in[2], pins_in[0]};
      MODE_ILV_Y:  chan_out = pins_in;
      4'h8, 4'h9, 4'ha, 4'hb: chan_out = cnt_q;
      default:     chan_out = chan_field_in;
    endcase
  end
endmodule : ddcsel_chan_sel

// File: tb/ddcsel_top_tb.sv
// Purpose : Self-checking bench for source, rate and channel selection.
// Assumes : The slave answers in its own time; the bus task waits for ack.
// Notes   : Outputs are checked mid-cycle, two edges after their cause.
`timescale 1ns/1ps
module ddcsel_top_tb;
  import ddcsel_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic             sys_clk, rst_b, cyc, stb, wbwe, ack;
  logic [11:0]      wadr;
  logic [3:0]       wsel, pins, m;
  logic [31:0]      wdat, rdat, rd;
  logic [STG_W-1:0] stage;
  logic [DEC_W-1:0] decim;
  logic             ok, real_o, isrc, qsrc;
  logic [3:0]       chan;
  int               err_total, tests_run, k, r, n;
  // Extended rate table: code, stages, complex and real decimation
  localparam logic [3:0] EC  [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
  localparam logic [6:0] ES  [7] = '{7'h2f, 7'h41, 7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
  localparam logic [5:0] EDC [7] = '{6'h30, 6'h0a, 6'h14, 6'h28, 6'h03, 6'h0f, 6'h1e};
  localparam logic [5:0] EDR [7] = '{6'h18, 6'h05, 6'h0a, 6'h14, 6'h00, 6'h00, 6'h00};

  ddcsel_top dut_u (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(wbwe), .wb_adr_in(wadr), .wb_sel_in(wsel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .pin_a_first_in(pins[0]), .pin_a_second_in(pins[1]), .pin_b_first_in(pins[2]),
    .pin_b_second_in(pins[3]), .stage_en_out(stage), .decim_factor_out(decim),
    .rate_ok_out(ok), .real_only_out(real_o), .i_src_b_out(isrc),
    .q_src_b_out(qsrc), .nco_chan_out(chan));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ack and data are read at the rising edge, before its updates land
  task automatic xfer(input logic we, input logic [11:0] a, input logic [7:0] d);
    int c;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= we;
    wadr <= a;
    wdat <= {24'h0, d};
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (ack !== 1'b1 && c < 16);
    if (c >= 16) err_total++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic pin_set(input logic [3:0] v);
    @(posedge sys_clk);
    pins <= v;
  endtask : pin_set

  // Pin-driven channel number per source mode, pins {b1,b0,a1,a0}
  function automatic logic [3:0] pin_chan(input logic [3:0] md, input logic [3:0] p);
    case (md)
      4'h1: pin_chan = {2'b00, p[2], p[0]};
      4'h2: pin_chan = {2'b00, p[3], p[1]};
      4'h3: pin_chan = {2'b00, p[1], p[0]};
      4'h4: pin_chan = {2'b00, p[3], p[2]};
      4'h5: pin_chan = {p[3], p[1], p[2], p[0]};
      default: pin_chan = {p[3], p[2], p[1], p[0]};
    endcase
  endfunction : pin_chan

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Whole run is a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, cyc, stb, wbwe, wadr, wdat, pins, err_total, tests_run} = '0;
    wsel = 4'h1;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    xfer(1'b0, 12'hc44, 8'h00);
    chk(rd, 32'h0);
    xfer(1'b0, 12'hc50, 8'h00);
    chk(rd, 32'h0);
    // Extended code ignored while main select is not seven
    xfer(1'b1, 12'hc44, 8'h90);
    settle();
    chk({25'h0, stage}, 32'h03);
    // Each of the seven decoded extended codes, complex then real output
    for (r = 0; r < 2; r++) begin
      xfer(1'b1, 12'hc40, {4'h0, r[0], 3'h7});
      for (k = 0; k < 7; k++) begin
        xfer(1'b1, 12'hc44, {EC[k], 4'h0});
        settle();
        n = (r == 0 || EDR[k] != 6'h0) ? 1 : 0;
        chk({25'h0, stage}, n ? {25'h0, ES[k]} : 32'h0);
        chk({26'h0, decim}, r ? {26'h0, EDR[k]} : {26'h0, EDC[k]});
        chk({31'h0, ok}, n);
        chk({31'h0, real_o}, r);
      end
    end
    xfer(1'b0, 12'hc40, 8'h00);
    chk(rd, 32'h0f);
    // Source routing and reserved bits
    xfer(1'b1, 12'hc40, 8'h00);
    xfer(1'b1, 12'hc44, 8'hff);
    xfer(1'b0, 12'hc44, 8'h00);
    chk(rd, 32'hf5);
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, 12'hc44, {5'h0, k[1], 1'b0, k[0]});
      settle();
      chk({30'h0, qsrc, isrc}, k);
    end
    // Unmapped place reads zero
    xfer(1'b1, 12'hc48, 8'h5a);
    xfer(1'b0, 12'hc48, 8'h00);
    chk(rd, 32'h0);
    // Register field, including reserved modes that fall back to it
    for (k = 0; k < 16; k++) begin
      m = (k < 8) ? 4'h0 : ((k < 12) ? 4'h7 : k[3:0]);
      xfer(1'b1, 12'hc50, {m, k[3:0] ^ 4'h5});
      settle();
      chk({28'h0, chan}, {28'h0, k[3:0] ^ 4'h5});
    end
    // Lane 0 off refuses the write; status shows the kept field
    @(posedge sys_clk);
    wsel <= 4'h0;
    xfer(1'b1, 12'hc50, 8'h00);
    wsel <= 4'h1;
    xfer(1'b0, 12'hc50, 8'h00);
    chk(rd, 32'hfa);
    xfer(1'b0, 12'hfc0, 8'h00);
    chk(rd, 32'h1a);
    // Pin-driven modes over several pin patterns
    for (k = 1; k < 7; k++) begin
      xfer(1'b1, 12'hc50, {k[3:0], 4'hf});
      for (r = 0; r < 4; r++) begin
        m = 4'h3 << r | 4'h8 >> r;
        pin_set(m);
        settle();
        chk({28'h0, chan}, {28'h0, pin_chan(k[3:0], m)});
      end
      pin_set(4'h0);
    end
    // Edge modes: wrong pin ignored, wrap after field value two
    for (k = 8; k < 12; k++) begin
      xfer(1'b1, 12'hc50, 8'h00);
      xfer(1'b1, 12'hc50, {k[3:0], 4'h2});
      pin_set(4'h1 << ((k - 7) % 4));
      pin_set(4'h0);
      settle();
      chk({28'h0, chan}, 32'h0);
      for (r = 1; r < 6; r++) begin
        pin_set(4'h1 << (k - 8));
        pin_set(4'h0);
        settle();
        chk({28'h0, chan}, r % 3);
      end
    end
    end_of_test();
  end
endmodule : ddcsel_top_tb
